//--- design/rpm_pulse_modulation_subsystem.sv
// Contract
// - Single pulse or pulse pair per period; reset gives single.
// - Period sets how often the pulse pattern repeats.
// - Polarity setting is ignored for the internal generator.
// - Normal blanks RF in pause, inverted blanks during pulse.
// - Source is internal generator or trigger pin; reset internal.
// - Enable bit switches modulation; resets to off.
// - Gate polarity normal or inverted chooses open level.
// - Triggered mode starts on chosen edge; reset rising.
// - Free-running mode repeats patterns without waiting; reset mode.
// - Edge mode begins a pattern on a trigger pin event.
// - Gated mode gates output by the trigger pin level.
// - Width sets pulse length, 20 ns minimum, 10 ns steps, 2 us reset.
// - First pulse follows start after a delay, reset 10 ns.
// - Second pulse starts a programmed time after the first, 40 ns min.
// - Second pulse has its own width.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rpm_pulse_modulation_subsystem (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rpm_pkg::AW-1:0] paddr_in,
  input wire logic [rpm_pkg::DW-1:0] pwdata_in,
  output logic [rpm_pkg::DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic trig_pin_in,
  output logic rf_on_out,
  output logic int_pulse_out
);
  import rpm_pkg::*;

  typedef struct packed {
    logic en;
    logic src_ext;
    logic pol_inv;
    logic pair;
    rpm_tmode_t tmode;
    logic falling;
    logic gate_inv;
    logic [VW-1:0] period;
    logic [VW-1:0] width;
    logic [VW-1:0] delay;
    logic [VW-1:0] dbl_delay;
    logic [VW-1:0] dbl_width;
    rpm_state_t state;
    logic [TW-1:0] t;
    logic trig_prev;
    logic pulse;
    logic rf_on;
    logic pready;
    logic pslverr;
    logic [DW-1:0] prdata;
  } rpm_st_t;

  rpm_st_t s_q;
  rpm_st_t s_d;
  logic trig_s;
  logic [TW-1:0] d1s;
  logic [TW-1:0] d1e;
  logic [TW-1:0] d2s;
  logic [TW-1:0] d2e;
  logic [TW-1:0] nxt;
  logic pat_end;
  logic run;
  logic p1;
  logic p2;
  logic pulse_now;
  logic gate_open;
  logic trig_edge;
  logic setup;
  logic wr;
  logic [DW-1:0] ctrl_rd;
  logic [DW-1:0] stat_rd;

  // ****************************************
  // Trigger pin synchroniser
  // ****************************************
  rpm_sync u_trig_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .async_in(trig_pin_in),
    .sync_out(trig_s)
  );

  // ****************************************
  // Pattern timing in ticks
  // ****************************************
  assign d1s = TW'(s_q.delay);
  assign d1e = d1s + TW'(s_q.width);
  assign d2s = d1s + TW'(s_q.dbl_delay);
  assign d2e = d2s + TW'(s_q.dbl_width);
  assign nxt = s_q.t + TW'(TICKS_PER_CLK);
  assign pat_end = nxt >= TW'(s_q.period);
  assign run = s_q.state == ST_RUN;
  assign p1 = run && s_q.t >= d1s && s_q.t < d1e;
  assign p2 = run && s_q.pair && s_q.t >= d2s && s_q.t < d2e;
  assign pulse_now = p1 || p2;
  assign gate_open = trig_s ^ s_q.gate_inv;
  assign trig_edge = s_q.falling ? (!trig_s && s_q.trig_prev)
                                 : (trig_s && !s_q.trig_prev);

  // ****************************************
  // Register bus
  // ****************************************
  assign setup = psel_in && !penable_in;
  assign wr = psel_in && penable_in && pwrite_in && s_q.pready;
  assign ctrl_rd = DW'({s_q.gate_inv, s_q.falling, s_q.tmode, s_q.pair,
                        s_q.pol_inv, s_q.src_ext, s_q.en});
  assign stat_rd = DW'({trig_s, gate_open, s_q.pulse, run});

  always_comb begin
    s_d = s_q;
    s_d.trig_prev = trig_s;
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    s_d.prdata = '0;
    if (setup) begin
      unique case (paddr_in)
        ADDR_CTRL: s_d.prdata = ctrl_rd;
        ADDR_PERIOD: s_d.prdata = s_q.period;
        ADDR_WIDTH: s_d.prdata = s_q.width;
        ADDR_DELAY: s_d.prdata = s_q.delay;
        ADDR_DBL_DELAY: s_d.prdata = s_q.dbl_delay;
        ADDR_DBL_WIDTH: s_d.prdata = s_q.dbl_width;
        ADDR_STATUS: s_d.prdata = stat_rd;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr_in)
        ADDR_CTRL: begin
          s_d.en = pwdata_in[CTRL_EN];
          s_d.src_ext = pwdata_in[CTRL_SRC_EXT];
          s_d.pol_inv = pwdata_in[CTRL_POL_INV];
          s_d.pair = pwdata_in[CTRL_PAIR];
          s_d.tmode = rpm_tmode_t'(pwdata_in[CTRL_TMODE_HI:CTRL_TMODE_LO]);
          s_d.falling = pwdata_in[CTRL_FALLING];
          s_d.gate_inv = pwdata_in[CTRL_GATE_INV];
        end
        ADDR_PERIOD: s_d.period = pwdata_in;
        ADDR_WIDTH: begin
          s_d.width = (pwdata_in < WIDTH_MIN) ? WIDTH_MIN : pwdata_in;
        end
        ADDR_DELAY: s_d.delay = pwdata_in;
        ADDR_DBL_DELAY: begin
          s_d.dbl_delay = (pwdata_in < DBL_DELAY_MIN) ? DBL_DELAY_MIN
                                                      : pwdata_in;
        end
        ADDR_DBL_WIDTH: s_d.dbl_width = pwdata_in;
        default: s_d.en = s_q.en;
      endcase
    end

    // Pattern sequencer
    unique case (s_q.state)
      ST_IDLE: begin
        s_d.t = '0;
        if (s_q.en) begin
          if (s_q.tmode == TMODE_EXT) begin
            if (trig_edge) begin
              s_d.state = ST_RUN;
            end
          end else if (s_q.tmode == TMODE_GATED_RUN_MODE) begin
            if (gate_open) begin
              s_d.state = ST_RUN;
            end
          end else begin
            s_d.state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        s_d.t = nxt;
        if (!s_q.en) begin
          s_d.state = ST_IDLE;
        end else if (s_q.tmode == TMODE_GATED_RUN_MODE && !gate_open) begin
          s_d.state = ST_IDLE;
        end else if (pat_end) begin
          s_d.t = '0;
          if (s_q.tmode == TMODE_EXT) begin
            s_d.state = ST_IDLE;
          end
        end
      end
    endcase

    // Modulation output
    s_d.pulse = pulse_now;
    if (!s_q.en) begin
      s_d.rf_on = 1'b1;
    end else if (s_q.src_ext) begin
      s_d.rf_on = trig_s ^ s_q.pol_inv;
    end else begin
      s_d.rf_on = pulse_now;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.tmode <= TMODE_AUTO;
      s_q.period <= PERIOD_RST;
      s_q.width <= WIDTH_RST;
      s_q.delay <= DELAY_RST;
      s_q.dbl_delay <= DBL_DELAY_MIN;
      s_q.dbl_width <= DBL_WIDTH_RST;
      s_q.state <= ST_IDLE;
      s_q.rf_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_out = s_q.prdata;
  assign pready_out = s_q.pready;
  assign pslverr_out = s_q.pslverr;
  assign rf_on_out = s_q.rf_on;
  assign int_pulse_out = s_q.pulse;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_off_passes_rf: assert property (!s_q.en |=> rf_on_out)
    else $error("RF blanked while modulation off");
  a_ext_normal_pol: assert property (
    s_q.en && s_q.src_ext && !s_q.pol_inv |=> rf_on_out == $past(trig_s))
    else $error("External normal polarity wrong");
  a_ext_inv_pol: assert property (
    s_q.en && s_q.src_ext && s_q.pol_inv |=> rf_on_out != $past(trig_s))
    else $error("External inverted polarity wrong");
  a_int_src_used: assert property (
    s_q.en && !s_q.src_ext |=> rf_on_out == $past(pulse_now))
    else $error("Internal pulse not on output");
  a_single_no_p2: assert property (!s_q.pair |-> !p2)
    else $error("Second pulse in single mode");
  a_edge_starts: assert property (
    s_q.state == ST_IDLE && s_q.en && s_q.tmode == TMODE_EXT && trig_edge
    |=> s_q.state == ST_RUN && s_q.t == '0)
    else $error("Trigger edge did not start pattern");
  a_ext_waits: assert property (
    s_q.state == ST_IDLE && s_q.tmode == TMODE_EXT && !trig_edge
    |=> s_q.state == ST_IDLE)
    else $error("Started without trigger");
  a_auto_restarts: assert property (
    run && s_q.en && s_q.tmode == TMODE_AUTO && pat_end
    |=> run && s_q.t == '0)
    else $error("Free run did not repeat");
  a_gate_stops: assert property (
    s_q.en && s_q.tmode == TMODE_GATED_RUN_MODE && !gate_open
    |=> s_q.state == ST_IDLE ##1 !int_pulse_out)
    else $error("Closed gate did not stop");
  a_width_floor: assert property (s_q.width >= WIDTH_MIN)
    else $error("Width below minimum");
  a_pair_spacing: assert property (s_q.dbl_delay >= DBL_DELAY_MIN)
    else $error("Pair spacing below minimum");

  // ****************************************
  // Pattern checks
  // ****************************************
  a_first_pulse: assert property (
    run && s_q.t >= d1s && s_q.t < d1e |=> int_pulse_out)
    else $error("First pulse missing");
  a_second_pulse: assert property (
    run && s_q.pair && s_q.t >= d2s && s_q.t < d2e
    |=> int_pulse_out)
    else $error("Second pulse missing");
  a_single_gap: assert property (
    run && !s_q.pair && (s_q.t < d1s || s_q.t >= d1e)
    |=> !int_pulse_out)
    else $error("Pulse outside its width");
  a_idle_quiet: assert property (!run |=> !int_pulse_out)
    else $error("Pulse while idle");
  a_tick_step: assert property (
    run && s_q.en && !pat_end && s_q.tmode != TMODE_GATED_RUN_MODE
    |=> s_q.t == $past(s_q.t) + TW'(TICKS_PER_CLK))
    else $error("Timebase step wrong");
  a_edge_ends: assert property (
    run && s_q.en && s_q.tmode == TMODE_EXT && pat_end
    |=> s_q.state == ST_IDLE)
    else $error("Triggered pattern did not end");
  a_gate_restart: assert property (
    s_q.state == ST_IDLE && s_q.en && s_q.tmode == TMODE_GATED_RUN_MODE
    && gate_open |=> run && s_q.t == '0)
    else $error("Open gate did not restart");
  a_auto_starts: assert property (
    s_q.state == ST_IDLE && s_q.en && s_q.tmode == TMODE_AUTO |=> run)
    else $error("Free run did not start");
  a_fall_starts: assert property (
    s_q.state == ST_IDLE && s_q.en && s_q.tmode == TMODE_EXT
    && s_q.falling && $fell(trig_s) |=> run && s_q.t == '0)
    else $error("Falling edge did not start pattern");
  a_rise_starts: assert property (
    s_q.state == ST_IDLE && s_q.en && s_q.tmode == TMODE_EXT
    && !s_q.falling && $rose(trig_s) |=> run && s_q.t == '0)
    else $error("Rising edge did not start pattern");
endmodule
`default_nettype wire

//--- design/rpm_pkg.sv
package rpm_pkg;

  // ****************************************
  // Timebase
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 10;
  localparam int TICKS_PER_CLK = CLK_PERIOD_NS / TICK_NS;

  // ****************************************
  // Widths
  // ****************************************
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int VW = 32;
  localparam int TW = 34;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_PERIOD = 8'h04;
  localparam logic [AW-1:0] ADDR_WIDTH = 8'h08;
  localparam logic [AW-1:0] ADDR_DELAY = 8'h0C;
  localparam logic [AW-1:0] ADDR_DBL_DELAY = 8'h10;
  localparam logic [AW-1:0] ADDR_DBL_WIDTH = 8'h14;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h18;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_SRC_EXT = 1;
  localparam int CTRL_POL_INV = 2;
  localparam int CTRL_PAIR = 3;
  localparam int CTRL_TMODE_LO = 4;
  localparam int CTRL_TMODE_HI = 5;
  localparam int CTRL_FALLING = 6;
  localparam int CTRL_GATE_INV = 7;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int STAT_RUN = 0;
  localparam int STAT_PULSE = 1;
  localparam int STAT_GATE_OPEN = 2;
  localparam int STAT_TRIG = 3;

  // ****************************************
  // Times in ns, and minimums and reset values in ticks
  // ****************************************
  localparam int WIDTH_MIN_NS = 20;
  localparam int DBL_DELAY_MIN_NS = 40;
  localparam int WIDTH_RST_NS = 2000;
  localparam int DELAY_RST_NS = 10;
  localparam int PERIOD_RST_NS = 10000;
  localparam int DBL_WIDTH_RST_NS = 2000;
  localparam logic [VW-1:0] WIDTH_MIN = VW'(WIDTH_MIN_NS / TICK_NS);
  localparam logic [VW-1:0] DBL_DELAY_MIN = VW'(DBL_DELAY_MIN_NS / TICK_NS);
  localparam logic [VW-1:0] WIDTH_RST = VW'(WIDTH_RST_NS / TICK_NS);
  localparam logic [VW-1:0] DELAY_RST = VW'(DELAY_RST_NS / TICK_NS);
  localparam logic [VW-1:0] PERIOD_RST = VW'(PERIOD_RST_NS / TICK_NS);
  localparam logic [VW-1:0] DBL_WIDTH_RST = VW'(DBL_WIDTH_RST_NS / TICK_NS);

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    TMODE_AUTO = 2'h0,
    TMODE_EXT = 2'h1,
    TMODE_GATED_RUN_MODE = 2'h2
  } rpm_tmode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } rpm_state_t;

endpackage

//--- design/rpm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rpm_sync (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic sync_out
);
  import rpm_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } rpm_sync_st_t;

  rpm_sync_st_t s_q;
  rpm_sync_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule
`default_nettype wire

//--- sim/rpm_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module rpm_trig_src (
  input wire logic core_clk_in,
  input wire logic level_in,
  output logic trig_out
);
  // ****
  // Pin follows the commanded level
  // ****
  always_ff @(posedge core_clk_in) begin
    trig_out <= level_in;
  end
endmodule
`default_nettype wire

//--- sim/rpm_pulse_modulation_subsystem_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rpm_pulse_modulation_subsystem_bench;
  import rpm_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic lvl = 0;
  logic [AW-1:0] pa = '0;
  logic [DW-1:0] pwd = '0;
  logic [DW-1:0] prd;
  logic prdy, perr, trig, rf, ip;
  int fail_count = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  rpm_trig_src rpm_trig_src_inst (.core_clk_in(clk), .level_in(lvl),
    .trig_out(trig));
  rpm_pulse_modulation_subsystem rpm_pulse_modulation_subsystem_inst (
    .core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .trig_pin_in(trig),
    .rf_on_out(rf), .int_pulse_out(ip));
  // ****
  // Helpers
  // ****
  task chk(string n, logic [DW-1:0] s, logic [DW-1:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task finish_test();
    $display("checks %0d fails %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task apb(logic w, logic [AW-1:0] a, logic [DW-1:0] d,
           output logic [DW-1:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    if (prdy !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    r = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task wr(logic [AW-1:0] a, logic [DW-1:0] d);
    logic [DW-1:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task rdc(string n, logic [AW-1:0] a, logic [DW-1:0] x);
    logic [DW-1:0] r;
    logic e;
    apb(0, a, '0, r, e);
    chk(n, r, x);
  endtask
  // Counts high cycles of the pulse or of the RF enable
  task cnt(int n, logic s, output logic [DW-1:0] c);
    c = '0;
    repeat (n) begin
      @(posedge clk);
      c = c + (s ? ip : rf);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task t_reset();
    logic [DW-1:0] r;
    logic e;
    chk("rf_idle", rf, 1);
    rdc("ctrl", ADDR_CTRL, 0);
    rdc("width", ADDR_WIDTH, WIDTH_RST);
    rdc("delay", ADDR_DELAY, DELAY_RST);
    rdc("period", ADDR_PERIOD, PERIOD_RST);
    rdc("dspace", ADDR_DBL_DELAY, DBL_DELAY_MIN);
    rdc("dwidth", ADDR_DBL_WIDTH, DBL_WIDTH_RST);
    rdc("status", ADDR_STATUS, 0);
    wr(ADDR_WIDTH, 1);
    rdc("wmin", ADDR_WIDTH, WIDTH_MIN);
    wr(ADDR_DBL_DELAY, 1);
    rdc("dmin", ADDR_DBL_DELAY, DBL_DELAY_MIN);
    apb(0, 8'h40, '0, r, e);
    chk("unmapped", e, 1);
  endtask
  task t_auto();
    logic [DW-1:0] c;
    wr(ADDR_PERIOD, 40);
    wr(ADDR_WIDTH, 10);
    wr(ADDR_CTRL, 1);
    repeat (8) @(posedge clk);
    cnt(80, 1, c);
    chk("auto", c, 20);
    cnt(80, 0, c);
    chk("rf_int", c, 20);
    wr(ADDR_CTRL, 5);
    cnt(80, 0, c);
    chk("rf_pol", c, 20);
    wr(ADDR_DBL_DELAY, 20);
    wr(ADDR_DBL_WIDTH, 10);
    wr(ADDR_CTRL, 9);
    repeat (8) @(posedge clk);
    cnt(80, 1, c);
    chk("pair", c, 40);
  endtask
  task t_ext();
    wr(ADDR_CTRL, 3);
    lvl <= 1;
    repeat (6) @(posedge clk);
    chk("ext_hi", rf, 1);
    lvl <= 0;
    repeat (6) @(posedge clk);
    chk("ext_lo", rf, 0);
    wr(ADDR_CTRL, 7);
    repeat (6) @(posedge clk);
    chk("ext_inv", rf, 1);
  endtask
  task t_edge();
    logic [DW-1:0] c;
    wr(ADDR_CTRL, 81);
    repeat (10) @(posedge clk);
    lvl <= 1;
    cnt(40, 1, c);
    chk("no_rise", c, 0);
    lvl <= 0;
    cnt(40, 1, c);
    chk("fall", c, 2);
    wr(ADDR_CTRL, 17);
    lvl <= 1;
    cnt(40, 1, c);
    chk("rise", c, 2);
  endtask
  task t_gate();
    logic [DW-1:0] c;
    lvl <= 0;
    wr(ADDR_CTRL, 33);
    repeat (8) @(posedge clk);
    cnt(40, 1, c);
    chk("closed", c, 0);
    lvl <= 1;
    repeat (8) @(posedge clk);
    cnt(40, 1, c);
    chk("open", c, 10);
    wr(ADDR_CTRL, 161);
    repeat (8) @(posedge clk);
    cnt(40, 1, c);
    chk("gate_inv", c, 0);
    rdc("stat_gate", ADDR_STATUS, 8);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    t_reset();
    t_auto();
    t_ext();
    t_edge();
    t_gate();
    finish_test();
  end
endmodule
`default_nettype wire
